/* hdl/rcr_axil_slave.sv */
`timescale 1ns/1ps
`include "rcr_cfg.svh"

module rcr_axil_slave (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [7:0]        awaddr,
   input  wire logic              wvalid,
   output logic                   wready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   output logic                   bvalid,
   input  wire logic              bready,
   output logic [1:0]             bresp,
   input  wire logic              arvalid,
   output logic                   arready,
   input  wire logic [7:0]        araddr,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output rcr_pkg::rcr_wreq_t     wreq,
   input  wire logic              wr_ok,
   output logic [7:0]             rd_addr,
   input  wire logic [31:0]       rd_data,
   input  wire logic              rd_ok
);
   import rcr_pkg::*;

   logic [7:0]  awa_reg;
   logic [31:0] wd_reg;
   logic        be0_reg;
   logic        wr_fire;
   logic        rd_fire;

   // ready flops drop once taken and return once the answer is accepted
   assign wr_fire = ~awready & ~wready & ~bvalid;
   assign rd_fire = ~arready & ~rvalid;
   assign wreq    = '{en: wr_fire, addr: awa_reg, data: wd_reg,
                      be0: be0_reg};

   // ===================================================================
   // write address and data, either order
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         awready <= 1'b1;
         awa_reg <= 8'h00;
      end else if (awready && awvalid) begin
         awready <= 1'b0;
         awa_reg <= awaddr;
      end else if (bvalid && bready) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wready  <= 1'b1;
         wd_reg  <= 32'h0000_0000;
         be0_reg <= 1'b0;
      end else if (wready && wvalid) begin
         wready  <= 1'b0;
         wd_reg  <= wdata;
         be0_reg <= wstrb[0];
      end else if (bvalid && bready) begin
         wready  <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bvalid <= 1'b0;
         bresp  <= `RCR_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp  <= wr_ok ? `RCR_RESP_OKAY : `RCR_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ===================================================================
   // read channel
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         arready <= 1'b1;
         rd_addr <= 8'h00;
      end else if (arready && arvalid) begin
         arready <= 1'b0;
         rd_addr <= araddr;
      end else if (rvalid && rready) begin
         arready <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `RCR_RESP_OKAY;
      end else if (rd_fire) begin
         rvalid <= 1'b1;
         rdata  <= rd_data;
         rresp  <= rd_ok ? `RCR_RESP_OKAY : `RCR_RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule : rcr_axil_slave

/* hdl/rcr_sync2.sv */
`timescale 1ns/1ps

module rcr_sync2 #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= RST;
         q        <= RST;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : rcr_sync2

/* hdl/rcr_top.sv */
`timescale 1ns/1ps
`include "rcr_cfg.svh"

module rcr_top (
   input  wire logic              CLK,
   input  wire logic              ARST_N,
   input  rcr_pkg::rcr_evt_t      EVT,
   input  wire logic              LOW_POWER_BROWNOUT_REQ,
   input  wire logic              EXTERNAL_RESET_PIN_N,
   input  wire logic              SLEEPING,
   input  wire logic              GLOBAL_INTERRUPT_ENABLE,
   input  wire logic              STACK_FAULT_RESET_ENABLE,
   input  wire logic [14:0]       CORE_PC,
   output logic                   CORE_HOLD,
   output logic                   CORE_START,
   output logic [14:0]            RESTART_PC,
   output logic                   VECTOR_AFTER_NEXT,
   output logic                   IRQ,
   input  wire logic              S_AXI_AWVALID,
   output logic                   S_AXI_AWREADY,
   input  wire logic [7:0]        S_AXI_AWADDR,
   input  wire logic              S_AXI_WVALID,
   output logic                   S_AXI_WREADY,
   input  wire logic [31:0]       S_AXI_WDATA,
   input  wire logic [3:0]        S_AXI_WSTRB,
   output logic                   S_AXI_BVALID,
   input  wire logic              S_AXI_BREADY,
   output logic [1:0]             S_AXI_BRESP,
   input  wire logic              S_AXI_ARVALID,
   output logic                   S_AXI_ARREADY,
   input  wire logic [7:0]        S_AXI_ARADDR,
   output logic                   S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY,
   output logic [31:0]            S_AXI_RDATA,
   output logic [1:0]             S_AXI_RRESP
);
   import rcr_pkg::*;

   rcr_wreq_t   wreq;
   logic [7:0]  rd_addr;
   logic [31:0] rd_data;
   logic        rd_ok;
   logic        wr_ok;
   logic        pin_n_s;
   logic [7:0]  flags_reg, flags_next;
   logic [7:0]  stat_reg, stat_next;
   logic [7:0]  ist_reg, ist_next;
   logic [7:0]  imsk_reg;
   rcr_state_t  state_reg, state_next;
   rcr_cause_t  cause_reg, cause_next;
   logic [14:0] pc_next;
   logic        idle, pin_low, blk, stk;
   logic        e_bor, e_pin, e_wdt_rst, e_wdt_wake, e_ri;
   logic        e_ovf, e_unf, e_iwake, e_rst, e_wake;
   logic        we_flags, we_stat, we_ist, we_imsk;

   // ===================================================================
   // bus slave
   rcr_axil_slave u_bus (
      .clk     (CLK),
      .arst_n  (ARST_N),
      .awvalid (S_AXI_AWVALID),
      .awready (S_AXI_AWREADY),
      .awaddr  (S_AXI_AWADDR),
      .wvalid  (S_AXI_WVALID),
      .wready  (S_AXI_WREADY),
      .wdata   (S_AXI_WDATA),
      .wstrb   (S_AXI_WSTRB),
      .bvalid  (S_AXI_BVALID),
      .bready  (S_AXI_BREADY),
      .bresp   (S_AXI_BRESP),
      .arvalid (S_AXI_ARVALID),
      .arready (S_AXI_ARREADY),
      .araddr  (S_AXI_ARADDR),
      .rvalid  (S_AXI_RVALID),
      .rready  (S_AXI_RREADY),
      .rdata   (S_AXI_RDATA),
      .rresp   (S_AXI_RRESP),
      .wreq    (wreq),
      .wr_ok   (wr_ok),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_ok   (rd_ok)
   );

   // pin is asynchronous; released level assumed at power-up
   rcr_sync2 #(.W(1), .RST(1'b1)) u_pin_sync (
      .clk    (CLK),
      .arst_n (ARST_N),
      .d      (EXTERNAL_RESET_PIN_N),
      .q      (pin_n_s)
   );

   // ===================================================================
   // event selection, one cause per edge, except a stack fault with an interrupt wake
   assign idle    = (state_reg == ST_IDLE);
   assign pin_low = ~pin_n_s;
   assign e_bor   = EVT.bor | LOW_POWER_BROWNOUT_REQ;
   assign blk     = e_bor | pin_low | EVT.wdt | EVT.rinst;
   assign e_pin   = idle & pin_low & ~e_bor;
   assign e_wdt_rst  = idle & EVT.wdt & ~SLEEPING & ~e_bor & ~pin_low;
   assign e_wdt_wake = idle & EVT.wdt & SLEEPING & ~e_bor & ~pin_low;
   assign e_ri    = idle & EVT.rinst & ~e_bor & ~pin_low & ~EVT.wdt;
   // stack faults only reset when enabled by configuration
   assign stk     = idle & STACK_FAULT_RESET_ENABLE & ~blk;
   assign e_ovf   = stk & EVT.ovf;
   assign e_unf   = stk & EVT.unf & ~EVT.ovf;
   assign e_iwake = idle & SLEEPING & EVT.int_wake & ~blk;
   assign e_rst   = e_bor | e_pin | e_wdt_rst | e_ri | e_ovf | e_unf;
   assign e_wake  = e_wdt_wake | e_iwake;

   assign we_flags = wreq.en & wreq.be0 & (wreq.addr == `RCR_OFS_FLAGS);
   assign we_stat  = wreq.en & wreq.be0 & (wreq.addr == `RCR_OFS_STAT);
   assign we_ist   = wreq.en & wreq.be0 & (wreq.addr == `RCR_OFS_IST);
   assign we_imsk  = wreq.en & wreq.be0 & (wreq.addr == `RCR_OFS_IMSK);

   // ===================================================================
   // cause flags: software first, hardware wins
   always_comb begin
      flags_next = flags_reg;
      if (we_flags) begin
         flags_next = (flags_reg & ~`RCR_FLAGS_WMASK)
                    | (wreq.data[7:0] & `RCR_FLAGS_WMASK);
      end
      if (e_bor) begin
         flags_next[`RCR_B_OVF] = 1'b0;
         flags_next[`RCR_B_UNF] = 1'b0;
         flags_next[`RCR_B_WDT] = 1'b1;
         flags_next[`RCR_B_PIN] = 1'b1;
         flags_next[`RCR_B_BOR] = 1'b0;
      end
      if (e_wdt_rst) flags_next[`RCR_B_WDT] = 1'b0;
      if (e_pin)     flags_next[`RCR_B_PIN] = 1'b0;
      if (e_ri)      flags_next[`RCR_B_RI]  = 1'b0;
      if (e_ovf)     flags_next[`RCR_B_OVF] = 1'b1;
      if (e_unf)     flags_next[`RCR_B_UNF] = 1'b1;
   end

   // timeout and powerdown mark the cause
   always_comb begin
      stat_next = stat_reg;
      if (we_stat) begin
         stat_next = (stat_reg & ~`RCR_STAT_WMASK)
                   | (wreq.data[7:0] & `RCR_STAT_WMASK);
      end
      if (e_bor) begin
         stat_next[`RCR_B_TO] = 1'b1;
         stat_next[`RCR_B_PD] = 1'b1;
      end
      if (e_wdt_rst) stat_next[`RCR_B_TO] = 1'b0;
      if (e_wdt_wake) begin
         stat_next[`RCR_B_TO] = 1'b0;
         stat_next[`RCR_B_PD] = 1'b0;
      end
      if (e_iwake || (e_pin && SLEEPING)) begin
         stat_next[`RCR_B_TO] = 1'b1;
         stat_next[`RCR_B_PD] = 1'b0;
      end
   end

   // power-on values; bit 5 never stored
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         flags_reg <= `RCR_FLAGS_POR;
         stat_reg  <= `RCR_STAT_POR;
      end else begin
         flags_reg <= flags_next;
         stat_reg  <= stat_next;
      end
   end

   // ===================================================================
   // interrupt status, write one to clear, set wins
   always_comb begin
      ist_next = ist_reg;
      if (we_ist) ist_next = ist_reg & ~wreq.data[7:0];
      ist_next = ist_next | {1'b0, e_wake, e_unf, e_ovf, e_ri,
                             e_pin, e_wdt_rst, e_bor};
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ist_reg  <= 8'h00;
         imsk_reg <= `RCR_IMSK_RST;
         IRQ      <= 1'b0;
      end else begin
         ist_reg  <= ist_next;
         if (we_imsk) imsk_reg <= {1'b0, wreq.data[6:0]};
         IRQ      <= |(ist_reg & imsk_reg);
      end
   end

   // ===================================================================
   // restart sequencing
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (e_rst) state_next = ST_HOLD;
            else if (e_wake) state_next = ST_START;
         end
         // hold until the pin lets go and brownout ends
         ST_HOLD: begin
            if (!(e_bor || pin_low)) state_next = ST_START;
         end
         ST_START: begin
            state_next = e_bor ? ST_HOLD : ST_IDLE;
         end
         default: state_next = ST_HOLD;
      endcase
   end

   // restart vector; wake resumes after sleep
   always_comb begin
      pc_next    = RESTART_PC;
      cause_next = cause_reg;
      if (e_bor) begin
         pc_next    = `RCR_PC_RESET;
         cause_next = CS_BOR;
      end else if (e_rst) begin
         pc_next    = `RCR_PC_RESET;
         cause_next = e_pin ? (SLEEPING ? CS_PINSLP : CS_PIN)
                    : e_wdt_rst ? CS_WDT : e_ri ? CS_RI
                    : e_ovf ? CS_OVF : CS_UNF;
      end else if (e_wake) begin
         pc_next    = 15'(CORE_PC + 15'h0001);
         cause_next = e_iwake ? CS_IWAKE : CS_WWAKE;
      end
   end

   // core held from power-on, then started at zero
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_reg         <= ST_HOLD;
         cause_reg         <= CS_POR;
         CORE_HOLD         <= 1'b1;
         CORE_START        <= 1'b0;
         RESTART_PC        <= `RCR_PC_RESET;
         VECTOR_AFTER_NEXT <= 1'b0;
      end else begin
         state_reg  <= state_next;
         cause_reg  <= cause_next;
         CORE_HOLD  <= (state_next == ST_HOLD);
         CORE_START <= (state_next == ST_START);
         RESTART_PC <= pc_next;
         if (e_rst || e_wake) begin
            VECTOR_AFTER_NEXT <= e_iwake & GLOBAL_INTERRUPT_ENABLE;
         end
      end
   end

   // ===================================================================
   // register read mux
   always_comb begin
      rd_ok   = 1'b1;
      rd_data = 32'h0000_0000;
      unique case (rd_addr)
         `RCR_OFS_FLAGS: rd_data = 32'(flags_reg);
         `RCR_OFS_STAT:  rd_data = 32'(stat_reg);
         `RCR_OFS_IST:   rd_data = 32'(ist_reg);
         `RCR_OFS_IMSK:  rd_data = 32'(imsk_reg);
         `RCR_OFS_INFO:  rd_data = 32'({state_reg, 2'b00, cause_reg});
         default:        rd_ok   = 1'b0;
      endcase
   end

   always_comb begin
      unique case (wreq.addr)
         `RCR_OFS_FLAGS, `RCR_OFS_STAT, `RCR_OFS_IST,
         `RCR_OFS_IMSK, `RCR_OFS_INFO: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // ===================================================================
   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   chk_bor_flags: assert property (
      e_bor |=> !flags_reg[`RCR_B_OVF] && !flags_reg[`RCR_B_UNF]
             && flags_reg[`RCR_B_WDT] && flags_reg[`RCR_B_PIN]
             && !flags_reg[`RCR_B_BOR] && stat_reg[`RCR_B_TO]
             && stat_reg[`RCR_B_PD] && RESTART_PC == `RCR_PC_RESET)
      else $error("brownout flags wrong");

   chk_wdt_reset: assert property (
      e_wdt_rst |=> !flags_reg[`RCR_B_WDT] && !stat_reg[`RCR_B_TO]
                 && stat_reg[`RCR_B_PD] == $past(stat_reg[`RCR_B_PD])
                 && CORE_HOLD ##1 CORE_START && RESTART_PC == 15'h0000)
      else $error("watchdog reset wrong");

   chk_wdt_wake: assert property (
      e_wdt_wake && !we_flags |=> !stat_reg[`RCR_B_TO]
         && !stat_reg[`RCR_B_PD] && flags_reg == $past(flags_reg)
         && CORE_START && RESTART_PC == 15'($past(CORE_PC) + 15'h0001))
      else $error("watchdog wake wrong");

   chk_int_wake: assert property (
      e_iwake |=> stat_reg[`RCR_B_TO] && !stat_reg[`RCR_B_PD]
         && CORE_START && !CORE_HOLD
         && VECTOR_AFTER_NEXT == $past(GLOBAL_INTERRUPT_ENABLE))
      else $error("interrupt wake wrong");

   chk_pin_awake: assert property (
      e_pin && !SLEEPING |=> !flags_reg[`RCR_B_PIN]
         && stat_reg[4:3] == $past(stat_reg[4:3]) && CORE_HOLD)
      else $error("pin reset wrong");

   chk_pin_sleep: assert property (
      e_pin && SLEEPING |=> !flags_reg[`RCR_B_PIN]
         && stat_reg[`RCR_B_TO] && !stat_reg[`RCR_B_PD])
      else $error("pin reset in sleep wrong");

   chk_reset_instr: assert property (
      e_ri && !we_flags |=> !flags_reg[`RCR_B_RI]
         && flags_reg[7:3] == $past(flags_reg[7:3]) && CORE_HOLD
         ##1 CORE_START && RESTART_PC == 15'h0000)
      else $error("reset instruction wrong");

   chk_stack_ovf: assert property (
      e_ovf |=> flags_reg[`RCR_B_OVF] && CORE_HOLD)
      else $error("overflow flag not set");

   chk_stack_unf: assert property (
      e_unf |=> flags_reg[`RCR_B_UNF] && CORE_HOLD)
      else $error("underflow flag not set");

   chk_stack_sticky: assert property (
      $rose(flags_reg[`RCR_B_OVF]) |-> $past(e_ovf) || $past(we_flags))
      else $error("overflow flag set without cause");

   chk_por_keep: assert property (
      $fell(flags_reg[`RCR_B_POR]) |-> $past(we_flags))
      else $error("power-on flag cleared by hardware");

   chk_unused_zero: assert property (
      flags_reg[5] == 1'b0 && stat_reg[7:5] == 3'b000)
      else $error("unimplemented bit set");

   chk_start_after: assert property (
      CORE_START |-> $past(CORE_HOLD) || $past(e_wake))
      else $error("start without prior update");

   chk_irq_level: assert property (
      ##1 IRQ == $past(|(ist_reg & imsk_reg)))
      else $error("interrupt level wrong");

   cov_bor_restart: cover property (e_bor ##1 CORE_HOLD ##1 CORE_START);
   cov_int_vector:  cover property (e_iwake && GLOBAL_INTERRUPT_ENABLE);
   cov_pin_held:    cover property (e_pin ##1 CORE_HOLD [*4] ##1 CORE_START);

endmodule : rcr_top

/* include/rcr_cfg.svh */
`ifndef RCR_CFG_SVH
`define RCR_CFG_SVH

// ======================================================================
// register offsets (byte addresses, one aligned word each)
`define RCR_OFS_FLAGS    8'h00
`define RCR_OFS_STAT     8'h04
`define RCR_OFS_IST      8'h08
`define RCR_OFS_IMSK     8'h0C
`define RCR_OFS_INFO     8'h10

// ======================================================================
// field positions
`define RCR_B_OVF        7
`define RCR_B_UNF        6
`define RCR_B_WDT        4
`define RCR_B_PIN        3
`define RCR_B_RI         2
`define RCR_B_POR        1
`define RCR_B_BOR        0
`define RCR_B_TO         4
`define RCR_B_PD         3

// ======================================================================
// reset values, write masks, restart vectors and bus response codes
`define RCR_FLAGS_POR    8'h1C
`define RCR_FLAGS_WMASK  8'hDF
`define RCR_STAT_POR     8'h18
`define RCR_STAT_WMASK   8'h07
`define RCR_IMSK_RST     8'h00
`define RCR_PC_RESET     15'h0000
`define RCR_PC_VECTOR    15'h0004
`define RCR_RESP_OKAY    2'h0
`define RCR_RESP_SLVERR  2'h2

`endif

/* include/rcr_pkg.sv */
package rcr_pkg;

   // ===================================================================
   // event pulses from on-chip sources, same clock
   typedef struct packed {
      logic bor;
      logic wdt;
      logic rinst;
      logic ovf;
      logic unf;
      logic int_wake;
   } rcr_evt_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_HOLD  = 2'b01,
      ST_START = 2'b11
   } rcr_state_t;

   typedef enum logic [3:0] {
      CS_POR, CS_BOR, CS_WDT, CS_WWAKE, CS_IWAKE,
      CS_PIN, CS_PINSLP, CS_RI, CS_OVF, CS_UNF
   } rcr_cause_t;

   typedef struct packed {
      logic        en;
      logic [7:0]  addr;
      logic [31:0] data;
      logic        be0;
   } rcr_wreq_t;

endpackage : rcr_pkg

/* test/rcr_core_model.sv */
`timescale 1ns/1ps
// ======================================================================
// core stand-in: runs its pc, freezes asleep, reloads at start
module rcr_core_model (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        hold,
   input  wire logic        start,
   input  wire logic        sleeping,
   input  wire logic [14:0] restart_pc,
   output logic      [14:0] pc
);
   // pc must not move while asleep, else wake targets drift
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         pc <= 15'h0000;
      else if (start)
         pc <= restart_pc;
      else if (!hold && !sleeping)
         pc <= pc + 15'h0001;
   end
endmodule : rcr_core_model

/* test/tb.sv */
`timescale 1ns/1ps
`include "rcr_cfg.svh"
module tb;
   import rcr_pkg::*;
   logic        clk, arst_n, lpb, pin_n, slp, global_interrupt_enable, sfe, awv, wv, bre, arv;
   logic        rre, awr, wrd, bv, arr, rv, hold, strt, vec, irq;
   logic [7:0]  awa, ara, fl, st;
   logic [31:0] wd, rdata, seed, v;
   logic [1:0]  bresp, rresp;
   logic [3:0]  ws;
   logic [14:0] rpc, pc;
   rcr_evt_t    evt;
   logic [33:0] rq[$];
   logic [15:0] pq[$];
   int          errors, check_count;

   rcr_top i_rcr_top (.CLK(clk), .ARST_N(arst_n), .EVT(evt),
      .LOW_POWER_BROWNOUT_REQ(lpb), .EXTERNAL_RESET_PIN_N(pin_n),
      .SLEEPING(slp), .GLOBAL_INTERRUPT_ENABLE(global_interrupt_enable),
      .STACK_FAULT_RESET_ENABLE(sfe), .CORE_PC(pc), .CORE_HOLD(hold),
      .CORE_START(strt), .RESTART_PC(rpc), .VECTOR_AFTER_NEXT(vec),
      .IRQ(irq), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(bre), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rre), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp));

   rcr_core_model i_rcr_core_model (.clk(clk), .arst_n(arst_n),
      .hold(hold), .start(strt), .sleeping(slp), .restart_pc(rpc),
      .pc(pc));

   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end

   // ===================================================================
   // checking and closing
   task automatic chk(input string nm, input logic [33:0] s, e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic results;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results

   task automatic tmo;
      errors++;
      $display("Error handshake expected 1 seen 0");
      results();
   endtask : tmo

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   function automatic logic [33:0] ok(input logic [7:0] d);
      return {26'h000_0000, d};
   endfunction : ok

   // ===================================================================
   // bus master, holds each channel until its own ready
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bit got;
      got = 0;
      awv <= 1;
      wv <= 1;
      awa <= a;
      wd <= 32'(d);
      bre <= 1;
      for (int n = 0; n < 40 && !got; n++) begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wrd) wv <= 0;
         if (bv) got = 1;
      end
      bre <= 0;
      if (!got) tmo();
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      bit got;
      got = 0;
      rq.push_back(e);
      arv <= 1;
      ara <= a;
      rre <= 1;
      for (int n = 0; n < 40 && !got; n++) begin
         @(posedge clk);
         if (arr) arv <= 0;
         if (rv) got = 1;
      end
      rre <= 0;
      if (!got) tmo();
   endtask : rd

   task automatic rr;
      rd(`RCR_OFS_FLAGS, ok(fl));
      rd(`RCR_OFS_STAT, ok(st));
   endtask : rr

   // ===================================================================
   // event sources; a start that nobody expects finds an empty queue and is checked against x
   task automatic wt(input bit rs);
      bit got;
      got = 0;
      for (int n = 0; n < 30 && !got; n++) begin
         @(posedge clk);
         got = strt;
      end
      @(posedge clk);
      if (rs && !got) tmo();
   endtask : wt

   task automatic ev(input rcr_evt_t e, input bit lp, rs,
                     input logic [15:0] x);
      if (rs) pq.push_back(x);
      evt <= e;
      lpb <= lp;
      @(posedge clk);
      evt <= '0;
      lpb <= 0;
      wt(rs);
   endtask : ev

   task automatic pin;
      pq.push_back(16'h0000);
      pin_n <= 0;
      repeat (4) @(posedge clk);
      chk("hold", hold, 1);
      pin_n <= 1;
      wt(1);
   endtask : pin

   // ===================================================================
   // result watcher
   always @(posedge clk) begin
      if (rv && rre)
         chk("rdata", {rresp, rdata}, rq.size() ? rq.pop_front() : 'x);
      if (bv && bre)
         chk("bresp", bresp, `RCR_RESP_OKAY);
      if (strt)
         chk("restart", {vec, rpc}, pq.size() ? pq.pop_front() : 'x);
   end

   initial begin
      {arst_n, lpb, slp, global_interrupt_enable, awv, wv, bre, arv, rre} = '0;
      {pin_n, sfe} = 2'b11;
      {awa, ara, wd, evt, errors, check_count} = '0;
      ws = 4'hf;
      seed = 32'h845f_7cc3;
      pq.push_back(16'h0000);
      repeat (4) @(posedge clk);
      arst_n <= 1;
      @(posedge clk);
      fl = 8'h1c;
      st = 8'h18;
      rr();
      rd(8'h20, {2'h2, 32'h0000_0000});
      wr(`RCR_OFS_FLAGS, 8'hff);
      fl = 8'hdf;
      rr();
      wr(`RCR_OFS_FLAGS, 8'h1f);
      fl = 8'h1f;
      rr();
      // a write without byte lane 0 must leave the flags alone
      ws <= 4'h0;
      wr(`RCR_OFS_FLAGS, 8'h00);
      ws <= 4'hf;
      rr();
      $display("test power-on and flag access done");
      ev(6'h10, 0, 1, 16'h0000);
      fl = 8'h0f;
      st = 8'h08;
      rr();
      ev(6'h08, 0, 1, 16'h0000);
      fl = 8'h0b;
      rr();
      sfe <= 0;
      ev(6'h06, 0, 0, 16'h0000);
      rr();
      sfe <= 1;
      ev(6'h04, 0, 1, 16'h0000);
      fl = 8'h8b;
      rr();
      ev(6'h02, 0, 1, 16'h0000);
      fl = 8'hcb;
      rr();
      wr(`RCR_OFS_FLAGS, 8'hff);
      ev(6'h00, 1, 1, 16'h0000);
      fl = 8'h1e;
      st = 8'h18;
      rr();
      wr(`RCR_OFS_FLAGS, 8'hff);
      ev(6'h20, 0, 1, 16'h0000);
      rr();
      $display("test reset events done");
      repeat (2) begin
         v = xs();
         wr(`RCR_OFS_STAT, v[7:0]);
         st = {3'b000, st[4:3], v[2:0]};
         rr();
      end
      pin();
      fl = 8'h16;
      rr();
      wr(`RCR_OFS_FLAGS, 8'hff);
      slp <= 1;
      pin();
      slp <= 0;
      fl = 8'hd7;
      st = {3'b000, 2'b10, st[2:0]};
      rr();
      slp <= 1;
      @(posedge clk);
      ev(6'h10, 0, 1, {1'b0, pc + 15'h0001});
      slp <= 0;
      st = {3'b000, 2'b00, st[2:0]};
      rr();
      $display("test pin and wake done");
      rd(`RCR_OFS_IST, ok(8'h7f));
      chk("irq", irq, 0);
      wr(`RCR_OFS_IMSK, 8'h04);
      repeat (2) @(posedge clk);
      chk("irq", irq, 1);
      wr(`RCR_OFS_IST, 8'h04);
      repeat (2) @(posedge clk);
      chk("irq", irq, 0);
      rd(`RCR_OFS_IST, ok(8'h7b));
      global_interrupt_enable <= 1;
      slp <= 1;
      @(posedge clk);
      ev(6'h01, 0, 1, {1'b1, pc + 15'h0001});
      slp <= 0;
      st = {3'b000, 2'b10, st[2:0]};
      rr();
      $display("test interrupt and vector done");
      results();
   end
endmodule : tb
